// >>> verilog/regframe_cfg.svh
`ifndef REGFRAME_CFG_SVH
`define REGFRAME_CFG_SVH

// register byte offsets, one aligned word each
`define RF_OFS_FEAT 8'h00
`define RF_OFS_CMD 8'h04
`define RF_OFS_DEV 8'h08
`define RF_OFS_LBAL 8'h0c
`define RF_OFS_LBAM 8'h10
`define RF_OFS_LBAH 8'h14
`define RF_OFS_CNT 8'h18
`define RF_OFS_FEATX 8'h1c
`define RF_OFS_LBALX 8'h20
`define RF_OFS_LBAMX 8'h24
`define RF_OFS_LBAHX 8'h28
`define RF_OFS_CNTX 8'h2c
`define RF_OFS_CTL 8'h30
`define RF_OFS_STAT 8'h34
`define RF_OFS_ISTAT 8'h38
`define RF_OFS_IEN 8'h3c
`define RF_OFS_ICLR 8'h40
`define RF_OFS_LINK 8'h44

// shadow array slots
`define RF_SLOT_CMD 4'd1
`define RF_SLOT_CTL 4'd12

// bit positions
`define RF_BUSY_BIT 7
`define RF_DRQ_BIT 3
`define RF_SOFT_RESET_BIT_BIT 2
`define RF_C_BIT 15
`define RF_IRQ_SENT 0
`define RF_IRQ_ERR 1
`define RF_IRQ_BUSY 2
`define RF_IRQ_N 3

// reset values
`define RF_CTL_RST 8'h00
`define RF_STAT_RST 8'h00

// frame format
`define RF_TYPE_H2D 8'h27
`define RF_FIS_DWORDS 3'd5

// timing
`define RF_CLK_NS 20
`define RF_BUSY_MAX_NS 400
`define RF_BUSY_CYC (`RF_BUSY_MAX_NS / `RF_CLK_NS)

`endif

// >>> verilog/regframe_pkg.sv
`default_nettype none
package regframe_pkg;
    // thirteen shadow bytes, slot 12 is device control
    typedef logic [12:0][7:0] shadow_t;
    // five payload dwords
    typedef logic [4:0][31:0] frame_t;
    // sender states
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SEND = 2'b01,
        TX_ACK = 2'b10
    } tx_state_t;
endpackage : regframe_pkg
`default_nettype wire

// >>> verilog/regframe_if.sv
`timescale 1ns/1ps
`default_nettype none
interface regframe_if;
    // payload word with frame markers, throttled by ready
    logic [31:0] data;
    logic valid;
    logic sof;
    logic eof;
    logic ready;
    // end-of-frame answer from the receiver
    logic ack_valid;
    logic ack_good;
    modport host (
        output data, valid, sof, eof,
        input ready, ack_valid, ack_good
    );
    modport dev (
        input data, valid, sof, eof,
        output ready, ack_valid, ack_good
    );
endinterface : regframe_if
`default_nettype wire

// >>> verilog/regframe_pack.sv
`timescale 1ns/1ps
`default_nettype none
`include "regframe_cfg.svh"
module regframe_pack (
    // shadow contents and cause
    input wire regframe_pkg::shadow_t i_sh,
    input wire logic i_cmd_cause,
    // assembled payload
    output regframe_pkg::frame_t o_frame
);
    // dword 0: type, c flag, command, features
    assign o_frame[0] = {i_sh[0], i_sh[1], i_cmd_cause, 7'h00,
                         `RF_TYPE_H2D};
    // dword 1: lba low/mid/high, device
    assign o_frame[1] = {i_sh[2], i_sh[5], i_sh[4], i_sh[3]};
    // dword 2: expanded address bytes, expanded features on top
    assign o_frame[2] = {i_sh[7], i_sh[10], i_sh[9], i_sh[8]};
    // dword 3: counts and control, reserved byte zero
    assign o_frame[3] = {i_sh[12], 8'h00, i_sh[11], i_sh[6]};
    // dword 4 all reserved
    assign o_frame[4] = 32'h0000_0000;
endmodule : regframe_pack
`default_nettype wire

// >>> verilog/regframe_host.sv
// Functional notes
// - type code in lowest byte of dword 0
// - register frame type 27h, five dwords
// - c flag 1 for command, 0 control
// - software never sends c and soft reset
// - fields carry current shadow register values
// - command write starts a frame
// - control write sends only on change
// - snapshot both groups, c by cause
// - busy set within 400 ns of command
// - busy on soft reset rise only
// - block command block writes while busy
// - software avoids writes while busy, except reset
// - device updates copies, executes when c set
// - build, send, take ack, report result
// - decode type, route fields, report result
// - no state kept across frames
// - frames bounded by markers, throttled by ready
`timescale 1ns/1ps
`default_nettype none
`include "regframe_cfg.svh"
module regframe_host #(
    parameter logic [7:0] RESET_CMD = 8'h08, // reset command code
    parameter int BUSY_LIMIT_CYC = `RF_BUSY_CYC
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic [31:0] o_hrdata,
    output logic o_hresp,
    // interrupt
    output logic o_irq,
    // link to the device end
    regframe_if.host link
);
    // busy is raised one edge after the write, limit must allow that
    if (BUSY_LIMIT_CYC < 1) begin : g_bad_limit
        $error("busy limit below one cycle");
    end

    // register state
    regframe_pkg::shadow_t sh_r;
    logic [7:0] status_r;
    logic [7:0] status_nxt;
    logic [`RF_IRQ_N-1:0] ist_r;
    logic [`RF_IRQ_N-1:0] ien_r;
    logic [`RF_IRQ_N-1:0] iset;
    logic [`RF_IRQ_N-1:0] iclr;
    // bus phase state
    logic wr_q;
    logic rd_q;
    logic map_q;
    logic [7:0] ofs_q;
    logic addr_ok;
    logic [7:0] wb;
    logic [31:0] rd_word;
    // write decode
    logic sh_wr;
    logic blocked;
    logic sh_we;
    logic cmd_trig;
    logic ctl_trig;
    logic soft_reset_bit_rise;
    logic busy_set;
    logic busy_drq;
    // sender state
    regframe_pkg::tx_state_t st_r;
    regframe_pkg::frame_t frame_r;
    regframe_pkg::frame_t pkt;
    logic [2:0] widx_r;
    logic [2:0] widx_inc;
    logic pend_r;
    logic pend_c_r;
    logic start;
    logic ack_in;
    logic valid_r;
    logic sof_r;
    logic eof_r;
    logic [31:0] data_r;

    // true when the latched write data phase targets offset t
    function automatic logic hit(input logic [7:0] t);
        hit = wr_q & map_q & (ofs_q == t);
    endfunction : hit

    // read selection for the latched offset
    function automatic logic rhit(input logic [7:0] t);
        rhit = map_q & (ofs_q == t);
    endfunction : rhit

    // address phase qualifier
    assign addr_ok = i_hsel & i_htrans[1] & i_hready;
    assign wb = i_hwdata[7:0];

    // address phase capture
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            map_q <= 1'b0;
            ofs_q <= 8'h00;
        end else begin
            wr_q <= addr_ok & i_hwrite;
            rd_q <= addr_ok & ~i_hwrite;
            if (addr_ok) begin
                map_q <= (i_haddr[31:8] == 24'h00_0000) &
                         (i_haddr[1:0] == 2'b00);
                ofs_q <= i_haddr[7:0];
            end
        end
    end

    // one wait state on reads so a preceding write is visible
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_hreadyout <= 1'b1;
            o_hrdata <= 32'h0000_0000;
            o_hresp <= 1'b0;
        end else begin
            o_hreadyout <= ~(addr_ok & ~i_hwrite);
            o_hresp <= 1'b0;
            if (rd_q) begin
                o_hrdata <= rd_word;
            end
        end
    end

    // read mux, unmapped offsets read zero, clear register reads zero
    assign rd_word =
        (map_q & (ofs_q <= `RF_OFS_CTL)) ? {24'h0, sh_r[ofs_q[5:2]]} :
        rhit(`RF_OFS_STAT) ? {24'h0, status_r} :
        rhit(`RF_OFS_ISTAT) ? {29'h0, ist_r} :
        rhit(`RF_OFS_IEN) ? {29'h0, ien_r} :
        rhit(`RF_OFS_LINK) ? {27'h0, pend_r, pend_c_r, st_r, 1'b0} :
        32'h0000_0000;

    // write decode and access control
    assign sh_wr = wr_q & map_q & (ofs_q <= `RF_OFS_CTL);
    assign busy_drq = status_r[`RF_BUSY_BIT] | status_r[`RF_DRQ_BIT];
    assign blocked = sh_wr & (ofs_q < `RF_OFS_CTL) & busy_drq &
                     ~(hit(`RF_OFS_CMD) & (wb == RESET_CMD));
    assign sh_we = sh_wr & ~blocked;
    assign cmd_trig = sh_we & (ofs_q == `RF_OFS_CMD);
    assign ctl_trig = sh_we & (ofs_q == `RF_OFS_CTL) &
                      (wb != sh_r[`RF_SLOT_CTL]);
    assign soft_reset_bit_rise = ctl_trig & wb[`RF_SOFT_RESET_BIT_BIT] &
                       ~sh_r[`RF_SLOT_CTL][`RF_SOFT_RESET_BIT_BIT];
    assign busy_set = cmd_trig | soft_reset_bit_rise;

    // status write, hardware busy set wins over software
    assign status_nxt = (hit(`RF_OFS_STAT) ? wb : status_r) |
                        (busy_set ? (8'h01 << `RF_BUSY_BIT) : 8'h00);

    // shadow registers
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            sh_r <= '0;
            sh_r[`RF_SLOT_CTL] <= `RF_CTL_RST;
            status_r <= `RF_STAT_RST;
        end else begin
            if (sh_we) begin
                sh_r[ofs_q[5:2]] <= wb;
            end
            status_r <= status_nxt;
        end
    end

    // pending frame request, command cause sets the c flag
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            pend_r <= 1'b0;
            pend_c_r <= 1'b0;
        end else begin
            pend_r <= cmd_trig | ctl_trig | (pend_r & ~start);
            if (cmd_trig | ctl_trig) begin
                pend_c_r <= cmd_trig;
            end
        end
    end

    // payload assembly from current shadow contents
    regframe_pack u_pack (
        .i_sh(sh_r),
        .i_cmd_cause(pend_c_r),
        .o_frame(pkt)
    );

    assign start = (st_r == regframe_pkg::TX_IDLE) & pend_r;
    assign widx_inc = widx_r + 3'd1;
    assign ack_in = (st_r == regframe_pkg::TX_ACK) & link.ack_valid;

    // sender: snapshot, stream with markers, wait for answer
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= regframe_pkg::TX_IDLE;
            frame_r <= '0;
            widx_r <= 3'd0;
            valid_r <= 1'b0;
            sof_r <= 1'b0;
            eof_r <= 1'b0;
            data_r <= 32'h0000_0000;
        end else begin
            case (st_r)
                regframe_pkg::TX_IDLE: begin
                    if (pend_r) begin
                        frame_r <= pkt;
                        data_r <= pkt[0];
                        valid_r <= 1'b1;
                        sof_r <= 1'b1;
                        eof_r <= 1'b0;
                        widx_r <= 3'd0;
                        st_r <= regframe_pkg::TX_SEND;
                    end
                end
                regframe_pkg::TX_SEND: begin
                    if (link.ready) begin
                        if (widx_r == `RF_FIS_DWORDS - 3'd1) begin
                            valid_r <= 1'b0;
                            eof_r <= 1'b0;
                            st_r <= regframe_pkg::TX_ACK;
                        end else begin
                            widx_r <= widx_inc;
                            data_r <= frame_r[widx_inc];
                            sof_r <= 1'b0;
                            eof_r <= (widx_inc == `RF_FIS_DWORDS - 3'd1);
                        end
                    end
                end
                regframe_pkg::TX_ACK: begin
                    if (link.ack_valid) begin
                        st_r <= regframe_pkg::TX_IDLE;
                    end
                end
                default: begin
                    st_r <= regframe_pkg::TX_IDLE;
                end
            endcase
        end
    end

    // link outputs straight from flops
    assign link.data = data_r;
    assign link.valid = valid_r;
    assign link.sof = sof_r;
    assign link.eof = eof_r;

    // interrupt events: sent, refused, busy raised
    assign iset[`RF_IRQ_SENT] = ack_in & link.ack_good;
    assign iset[`RF_IRQ_ERR] = ack_in & ~link.ack_good;
    assign iset[`RF_IRQ_BUSY] = busy_set;
    assign iclr = hit(`RF_OFS_ICLR) ? wb[`RF_IRQ_N-1:0] : '0;

    // sticky status bits, set wins over clear
    for (genvar i = 0; i < `RF_IRQ_N; i++) begin : g_irq
        always_ff @(posedge i_sys_clk or posedge i_rst) begin
            if (i_rst) begin
                ist_r[i] <= 1'b0;
            end else begin
                ist_r[i] <= iset[i] | (ist_r[i] & ~iclr[i]);
            end
        end
    end

    // enable register and level interrupt
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ien_r <= '0;
            o_irq <= 1'b0;
        end else begin
            if (hit(`RF_OFS_IEN)) begin
                ien_r <= wb[`RF_IRQ_N-1:0];
            end
            o_irq <= |(ist_r & ien_r);
        end
    end
endmodule : regframe_host
`default_nettype wire

// >>> verilog/regframe_dev.sv
`timescale 1ns/1ps
`default_nettype none
`include "regframe_cfg.svh"
module regframe_dev (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // link from the host end
    regframe_if.dev link,
    // local register copies
    output logic [15:0] o_features,
    output logic [7:0] o_command,
    output logic [7:0] o_device,
    output logic [47:0] o_lba,
    output logic [15:0] o_count,
    output logic [7:0] o_control,
    // frame results, one-cycle pulses
    output logic o_exec,
    output logic o_rx_good,
    output logic o_rx_bad
);
    logic [3:0][31:0] w_r;
    logic [2:0] cnt_r;
    logic [2:0] pos;
    logic [2:0] nwords;
    logic [7:0] ftype;
    logic take;
    logic fin;
    logic good;
    logic ready_r;
    logic ack_v_r;
    logic ack_g_r;

    // word position: a start marker always restarts the count
    assign take = link.valid & ready_r;
    assign pos = link.sof ? 3'd0 : cnt_r;
    assign nwords = pos + 3'd1;
    assign fin = take & link.eof;
    assign ftype = link.sof ? link.data[7:0] : w_r[0][7:0];
    assign good = (ftype == `RF_TYPE_H2D) &
                  (nwords == `RF_FIS_DWORDS) & (cnt_r != 3'd7 | link.sof);

    // collect words 0 to 3, the fifth is ignored
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            w_r <= '0;
            cnt_r <= 3'd0;
            ready_r <= 1'b0;
        end else begin
            // pause one cycle after word 1 so the sender must hold
            ready_r <= ~(take & (pos == 3'd1));
            if (take) begin
                if (pos < 3'd4) begin
                    w_r[pos[1:0]] <= link.data;
                end
                cnt_r <= fin ? 3'd0 : ((pos == 3'd7) ? pos : nwords);
            end
        end
    end

    // decode and route a complete frame
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_features <= 16'h0000;
            o_command <= 8'h00;
            o_device <= 8'h00;
            o_lba <= 48'h0000_0000_0000;
            o_count <= 16'h0000;
            o_control <= 8'h00;
            o_exec <= 1'b0;
            o_rx_good <= 1'b0;
            o_rx_bad <= 1'b0;
            ack_v_r <= 1'b0;
            ack_g_r <= 1'b0;
        end else begin
            o_exec <= fin & good & w_r[0][`RF_C_BIT];
            o_rx_good <= fin & good;
            o_rx_bad <= fin & ~good;
            ack_v_r <= fin;
            ack_g_r <= good;
            if (fin & good) begin
                o_command <= w_r[0][23:16];
                o_features <= {w_r[2][31:24], w_r[0][31:24]};
                o_device <= w_r[1][31:24];
                o_lba <= {w_r[2][23:0], w_r[1][23:0]};
                o_count <= w_r[3][15:0];
                o_control <= w_r[3][31:24];
            end
        end
    end

    // link answers from flops
    assign link.ready = ready_r;
    assign link.ack_valid = ack_v_r;
    assign link.ack_good = ack_g_r;
endmodule : regframe_dev
`default_nettype wire

// >>> sim/regframe_properties.sv
`timescale 1ns/1ps
`default_nettype none
module regframe_properties (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // link signals
    input wire logic [31:0] data,
    input wire logic valid,
    input wire logic sof,
    input wire logic eof,
    input wire logic ready,
    input wire logic ack_valid,
    input wire logic ack_good
);
    logic [2:0] words_r;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    // words taken since the frame start
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst)
            words_r <= 3'h0;
        else if (valid && ready)
            words_r <= sof ? 3'h1 : words_r + 3'h1;
    end
    // frame markers
    sequence sof_shown;
        valid && sof;
    endsequence
    sequence eof_taken;
        valid && ready && eof;
    endsequence
    a_type_code: assert property (
        sof_shown |-> data[7:0] == 8'h27) else $error("bad frame type");
    a_sof_reserved: assert property (
        sof_shown |-> data[14:8] == 7'h0) else $error("dword0 reserved set");
    a_five_words: assert property (
        eof_taken |-> !sof && words_r == 3'h4) else $error("frame not 5 words");
    a_last_zero: assert property (
        valid && eof |-> data == 32'h0) else $error("dword4 not zero");
    a_dw3_gap: assert property (
        valid && !sof && words_r == 3'h3 |-> data[23:16] == 8'h0)
        else $error("dword3 reserved set");
    a_hold_word: assert property (
        valid && !ready |=> valid && $stable(data) && $stable(sof)
        && $stable(eof)) else $error("word dropped before ready");
    a_ack_follows: assert property (
        eof_taken |=> ack_valid && !valid) else $error("no ack after eof");
    a_ack_pulse: assert property (
        ack_valid |=> !ack_valid) else $error("ack longer than a cycle");
    a_ack_good: assert property (
        ack_valid |-> ack_good) else $error("good frame refused");
endmodule : regframe_properties
`default_nettype wire

// >>> sim/register_frame_transport_test.sv
`timescale 1ns/1ps
`default_nettype none
module register_frame_transport_test;
    logic sys_clk, rst, hsel, hwrite, hreadyout, hresp, irq, exec;
    logic rx_good, rx_bad;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [15:0] features, count;
    logic [7:0] command, device, control;
    logic [47:0] lba;
    logic [31:0] seen[$];
    int n_errors = 0;
    int n_compared = 0;
    int n_exec = 0;
    int n_good = 0;
    int n_bad = 0;
    int i;
    // both ends joined by the link
    regframe_if link ();
    regframe_host regframe_host_i (.i_sys_clk(sys_clk), .i_rst(rst),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hrdata(hrdata),
        .o_hresp(hresp), .o_irq(irq), .link(link.host));
    regframe_dev regframe_dev_i (.i_sys_clk(sys_clk), .i_rst(rst),
        .link(link.dev), .o_features(features), .o_command(command),
        .o_device(device), .o_lba(lba), .o_count(count),
        .o_control(control), .o_exec(exec), .o_rx_good(rx_good),
        .o_rx_bad(rx_bad));
    regframe_properties regframe_properties_i (.i_sys_clk(sys_clk),
        .i_rst(rst), .data(link.data), .valid(link.valid), .sof(link.sof),
        .eof(link.eof), .ready(link.ready), .ack_valid(link.ack_valid),
        .ack_good(link.ack_good));
    // clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // collect link words and command starts
    always @(posedge sys_clk) begin
        if (link.valid === 1'b1 && link.ready === 1'b1)
            seen.push_back(link.data);
        if (exec === 1'b1)
            n_exec++;
        if (rx_good === 1'b1)
            n_good++;
        if (rx_bad !== 1'b0)
            n_bad++;
    end
    function automatic logic [7:0] v(input int k);
        return 8'ha0 + k[7:0];
    endfunction : v
    task check(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // one single ahb-lite transfer
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
             output logic [31:0] rd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        check(hresp, 1'b0);
    endtask : ahb
    task wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask : wr
    task rdchk(input logic [31:0] a, input logic [31:0] m,
               input logic [31:0] e);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0, x);
        check(x & m, e);
    endtask : rdchk
    // wait for one frame, judge words and device copies
    task tkframe(input logic c, input logic [7:0] cmd, input logic [7:0] ctl,
                 input int dexec);
        regframe_pkg::frame_t f;
        int k;
        for (k = 0; k < 200 && seen.size() < 5; k++) @(posedge sys_clk);
        repeat (4) @(posedge sys_clk);
        check(seen.size(), 5);
        f = {32'h0, {ctl, 8'h00, v(11), v(6)}, {v(7), v(10), v(9), v(8)},
             {v(2), v(5), v(4), v(3)}, {v(0), cmd, c, 7'h00, 8'h27}};
        for (k = 0; k < 5; k++)
            check(seen.size() > 0 ? seen.pop_front() : 'x, f[k]);
        check(command, cmd);
        check(control, ctl);
        check({features, device, count}, {v(7), v(0), v(2), v(11), v(6)});
        check(lba, {v(10), v(9), v(8), v(5), v(4), v(3)});
        check(n_exec, dexec);
        check(n_good, 1);
        check(n_bad, 0);
        rdchk(32'h38, 32'h02, 32'h00);
        n_exec = 0;
        n_good = 0;
        n_bad = 0;
    endtask : tkframe
    // reset values and unmapped places
    task t_basic;
        rdchk(32'h30, 32'hff, 32'h00);
        rdchk(32'h34, 32'hff, 32'h00);
        wr(32'h48, 32'h5a);
        rdchk(32'h48, 32'hffffffff, 32'h0);
        rdchk(32'h104, 32'hffffffff, 32'h0);
    endtask : t_basic
    // command write sends a frame and raises busy
    task t_cmd_frame;
        for (i = 0; i < 12; i++)
            if (i != 1)
                wr(i * 4, v(i));
        wr(32'h04, 32'h25);
        rdchk(32'h34, 32'h80, 32'h80);
        tkframe(1'b1, 8'h25, 8'h00, 1);
    endtask : t_cmd_frame
    // writes while busy dropped, reset command let through
    task t_busy_block;
        wr(32'h00, 32'hee);
        rdchk(32'h00, 32'hff, 32'ha0);
        wr(32'h04, 32'h08);
        tkframe(1'b1, 8'h08, 8'h00, 1);
        wr(32'h34, 32'h00);
        rdchk(32'h34, 32'h80, 32'h00);
    endtask : t_busy_block
    // control writes: same value, change, soft reset rise
    task t_ctl_frames;
        wr(32'h30, 32'h00);
        repeat (20) @(posedge sys_clk);
        check(seen.size(), 0);
        wr(32'h30, 32'h02);
        tkframe(1'b0, 8'h08, 8'h02, 0);
        rdchk(32'h34, 32'h80, 32'h00);
        wr(32'h30, 32'h06);
        rdchk(32'h34, 32'h80, 32'h80);
        tkframe(1'b0, 8'h08, 8'h06, 0);
        wr(32'h34, 32'h00);
    endtask : t_ctl_frames
    // sent-ok interrupt masked, enabled, cleared
    task t_irq;
        wr(32'h3c, 32'h00);
        wr(32'h40, 32'h07);
        wr(32'h30, 32'h00);
        tkframe(1'b0, 8'h08, 8'h00, 0);
        rdchk(32'h38, 32'h01, 32'h01);
        @(negedge sys_clk);
        check(irq, 1'b0);
        wr(32'h3c, 32'h01);
        repeat (2) @(negedge sys_clk);
        check(irq, 1'b1);
        wr(32'h40, 32'h01);
        repeat (2) @(negedge sys_clk);
        check(irq, 1'b0);
        rdchk(32'h38, 32'h01, 32'h00);
    endtask : t_irq
    task give_verdict;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        give_verdict;
    end
    // main sequence
    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        t_basic;
        t_cmd_frame;
        t_busy_block;
        t_ctl_frames;
        t_irq;
        give_verdict;
    end
endmodule : register_frame_transport_test
`default_nettype wire
